// >>> src/fsmc_pkg.sv
// Package of the fan speed monitor: register map, field positions, reset values, timing
// Assumes an APB slave with 32-bit data and a single 50 MHz clock
package fsmc_pkg;
    localparam logic [11:0] FSMC_OFF_CTRL = 12'h000;
    localparam logic [11:0] FSMC_OFF_STAT = 12'h004;
    localparam logic [11:0] FSMC_OFF_HLIM = 12'h008;
    localparam logic [11:0] FSMC_OFF_LLIM = 12'h00c;
    localparam logic [11:0] FSMC_OFF_CLR = 12'h010;
    localparam logic [11:0] FSMC_OFF_IEN = 12'h014;

    localparam int FSMC_B_LIMIT_EN = 0;
    localparam int FSMC_B_ENABLE = 1;
    localparam int FSMC_B_FILTER = 8;
    localparam int FSMC_B_MODE = 10;
    localparam int FSMC_B_EDGES = 11;
    localparam int FSMC_B_READY_EN = 14;
    localparam int FSMC_B_TOGGLE_EN = 15;
    localparam int FSMC_B_COUNT = 16;

    localparam int FSMC_S_LIMIT = 0;
    localparam int FSMC_S_PIN = 1;
    localparam int FSMC_S_TOGGLE = 2;
    localparam int FSMC_S_READY = 3;

    localparam logic [15:0] FSMC_COUNT_MAX = 16'hffff;
    localparam logic [15:0] FSMC_HLIM_RST = 16'hffff;
    localparam logic [15:0] FSMC_LLIM_RST = 16'h0000;
    localparam logic [1:0] FSMC_FILT_TICKS = 2'h2;
    localparam logic [3:0] FSMC_EDGES_00 = 4'h2;
    localparam logic [3:0] FSMC_EDGES_01 = 4'h3;
    localparam logic [3:0] FSMC_EDGES_10 = 4'h5;
    localparam logic [3:0] FSMC_EDGES_11 = 4'h9;

    typedef enum logic [0:0] {
        FSMC_MODE_EDGE = 1'b0,
        FSMC_MODE_TICK = 1'b1
    } fsmc_mode_t;

    function automatic logic [3:0] fsmc_edge_target(input logic [1:0] sel);
        unique case (sel)
            2'h0: fsmc_edge_target = FSMC_EDGES_00;
            2'h1: fsmc_edge_target = FSMC_EDGES_01;
            2'h2: fsmc_edge_target = FSMC_EDGES_10;
            2'h3: fsmc_edge_target = FSMC_EDGES_11;
        endcase
    endfunction
endpackage

// >>> src/fsmc_sense_if.sv
// Interface between the monitor core and its speed-sense input filter
// Assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface fsmc_sense_if;
    logic raw;
    logic tick;
    logic run;
    logic filter_en;
    logic level;
    logic rise;
    logic fall;

    modport filt (input raw, input tick, input run, input filter_en, output level, output rise, output fall);
    modport core (output raw, output tick, output run, output filter_en, input level, input rise, input fall);
endinterface
`default_nettype wire

// >>> src/fsmc_filter.sv
// Speed-sense glitch filter and edge detector
// Assumes the raw input and the 100 kHz tick are synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
module fsmc_filter
    import fsmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    fsmc_sense_if.filt sense
);
    logic [1:0] agree;
    logic next_level;

    // With the filter on, accept a new level only when seen on three ticks in a row, i.e. held over two full tick periods
    always_comb begin
        next_level = sense.level;
        if (sense.run) begin
            if (!sense.filter_en) begin
                next_level = sense.raw;
            end else if (sense.raw != sense.level && sense.tick && agree == FSMC_FILT_TICKS) begin
                next_level = sense.raw;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agree <= 2'h0;
        end else if (!sense.run || sense.raw == sense.level || next_level != sense.level) begin
            agree <= 2'h0;
        end else if (sense.tick) begin
            agree <= agree + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense.level <= 1'b0;
            sense.rise <= 1'b0;
            sense.fall <= 1'b0;
        end else begin
            sense.level <= next_level;
            sense.rise <= next_level & ~sense.level;
            sense.fall <= ~next_level & sense.level;
        end
    end
endmodule
`default_nettype wire

// >>> src/fsmc_top.sv
// Fan speed monitor: APB registers, pulse and tick counting, limit checking, interrupt
// Assumes a 50 MHz pclk, a one-cycle 100 kHz tick pulse and a synchronous speed-sense input
`timescale 1ns/1ns
`default_nettype none
module fsmc_top
    import fsmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tick_100khz,
    input wire logic speed_sense_pin_in,
    output logic speed_sense_pin_out,
    output logic speed_sense_pin_oe,
    output logic irq
);
    fsmc_sense_if sense ();

    logic limit_irq_enable;
    logic monitor_enable;
    logic filter_enable;
    fsmc_mode_t count_mode;
    logic [1:0] edge_select;
    logic ready_irq_enable;
    logic toggle_irq_enable;
    logic [15:0] latched_pulse_count;
    logic [15:0] high_limit;
    logic [15:0] low_limit;
    logic [15:0] counter;
    logic [3:0] edges_seen;
    logic limit_violation_flag;
    logic toggle_flag;
    logic ready_flag;
    logic latch_now;
    logic [15:0] latch_value;
    logic [15:0] next_counter;
    logic [3:0] next_edges_seen;
    logic any_edge;
    logic wr;
    logic rd_setup;
    logic mapped;
    logic [3:0] status_word;
    logic [3:0] enable_word;
    logic [31:0] ctrl_word;

    assign sense.raw = speed_sense_pin_in;
    assign sense.tick = tick_100khz;
    assign sense.run = monitor_enable;
    assign sense.filter_en = filter_enable;

    fsmc_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .sense(sense)
    );

    // The pin is an input only and is never driven
    assign speed_sense_pin_out = 1'b0;
    assign speed_sense_pin_oe = 1'b0;

    // APB decode: zero wait states, error on an unmapped address
    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped = paddr == FSMC_OFF_CTRL || paddr == FSMC_OFF_STAT || paddr == FSMC_OFF_HLIM
        || paddr == FSMC_OFF_LLIM || paddr == FSMC_OFF_CLR || paddr == FSMC_OFF_IEN;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_irq_enable <= 1'b0;
            monitor_enable <= 1'b0;
            filter_enable <= 1'b0;
            count_mode <= FSMC_MODE_EDGE;
            edge_select <= 2'h0;
            ready_irq_enable <= 1'b0;
            toggle_irq_enable <= 1'b0;
        end else if (wr && paddr == FSMC_OFF_CTRL) begin
            limit_irq_enable <= pwdata[FSMC_B_LIMIT_EN];
            monitor_enable <= pwdata[FSMC_B_ENABLE];
            filter_enable <= pwdata[FSMC_B_FILTER];
            count_mode <= fsmc_mode_t'(pwdata[FSMC_B_MODE]);
            edge_select <= pwdata[FSMC_B_EDGES +: 2];
            ready_irq_enable <= pwdata[FSMC_B_READY_EN];
            toggle_irq_enable <= pwdata[FSMC_B_TOGGLE_EN];
        end else if (wr && paddr == FSMC_OFF_IEN) begin
            limit_irq_enable <= pwdata[FSMC_S_LIMIT];
            toggle_irq_enable <= pwdata[FSMC_S_TOGGLE];
            ready_irq_enable <= pwdata[FSMC_S_READY];
        end
    end

    // Limit registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_limit <= FSMC_HLIM_RST;
            low_limit <= FSMC_LLIM_RST;
        end else if (wr && paddr == FSMC_OFF_HLIM) begin
            high_limit <= pwdata[15:0];
        end else if (wr && paddr == FSMC_OFF_LLIM) begin
            low_limit <= pwdata[15:0];
        end
    end

    // Counting in both modes
    assign any_edge = sense.rise | sense.fall;

    always_comb begin
        next_counter = counter;
        next_edges_seen = edges_seen;
        latch_now = 1'b0;
        latch_value = counter;
        if (monitor_enable) begin
            if (count_mode == FSMC_MODE_EDGE) begin
                if (sense.rise) begin
                    next_counter = counter + 16'h0001;
                    latch_now = 1'b1;
                    latch_value = next_counter;
                end
            end else if (any_edge && edges_seen != 4'h0
                         && edges_seen + 4'h1 == fsmc_edge_target(edge_select)) begin
                latch_now = 1'b1;
                latch_value = counter;
                next_counter = 16'h0000;
                next_edges_seen = 4'h1;
            end else if (any_edge) begin
                next_edges_seen = edges_seen + 4'h1;
            end else if (tick_100khz && edges_seen != 4'h0) begin
                if (counter == FSMC_COUNT_MAX - 16'h0001) begin
                    latch_now = 1'b1;
                    latch_value = FSMC_COUNT_MAX;
                    next_counter = 16'h0000;
                    next_edges_seen = 4'h0;
                end else begin
                    next_counter = counter + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter <= 16'h0000;
            edges_seen <= 4'h0;
        end else begin
            counter <= next_counter;
            edges_seen <= next_edges_seen;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_pulse_count <= 16'h0000;
        end else if (latch_now) begin
            latched_pulse_count <= latch_value;
        end
    end

    // Sticky status: set wins over clear, nothing clears on disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_violation_flag <= 1'b0;
        end else if (latch_now && (latch_value > high_limit || latch_value < low_limit)) begin
            limit_violation_flag <= 1'b1;
        end else if (wr && paddr == FSMC_OFF_CLR && pwdata[FSMC_S_LIMIT]) begin
            limit_violation_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_flag <= 1'b0;
        end else if (monitor_enable && any_edge) begin
            toggle_flag <= 1'b1;
        end else if (wr && paddr == FSMC_OFF_CLR && pwdata[FSMC_S_TOGGLE]) begin
            toggle_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_flag <= 1'b0;
        end else if (latch_now && count_mode == FSMC_MODE_TICK) begin
            ready_flag <= 1'b1;
        end else if (wr && paddr == FSMC_OFF_CLR && pwdata[FSMC_S_READY]) begin
            ready_flag <= 1'b0;
        end
    end

    assign status_word = {ready_flag, toggle_flag, speed_sense_pin_in, limit_violation_flag};
    assign enable_word = {ready_irq_enable, toggle_irq_enable, 1'b0, limit_irq_enable};

    // Interrupt: any enabled status bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_word & enable_word & 4'hd);
        end
    end

    // Control word with reserved bits reading zero
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[FSMC_B_LIMIT_EN] = limit_irq_enable;
        ctrl_word[FSMC_B_ENABLE] = monitor_enable;
        ctrl_word[FSMC_B_FILTER] = filter_enable;
        ctrl_word[FSMC_B_MODE] = count_mode;
        ctrl_word[FSMC_B_EDGES +: 2] = edge_select;
        ctrl_word[FSMC_B_READY_EN] = ready_irq_enable;
        ctrl_word[FSMC_B_TOGGLE_EN] = toggle_irq_enable;
        ctrl_word[FSMC_B_COUNT +: 16] = latched_pulse_count;
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            unique case (paddr)
                FSMC_OFF_CTRL: prdata <= ctrl_word;
                FSMC_OFF_STAT: prdata <= {28'h0000000, status_word};
                FSMC_OFF_HLIM: prdata <= {16'h0000, high_limit};
                FSMC_OFF_LLIM: prdata <= {16'h0000, low_limit};
                FSMC_OFF_IEN: prdata <= {28'h0000000, enable_word};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> dv/fsmc_fan_model.sv
// Fan speed-sense model: square wave of a set half period and period count
// Assumes pclk timing; the output starts and ends low
`timescale 1ns/1ns
`default_nettype none
module fsmc_fan_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [15:0] half,
    input wire logic [7:0] periods,
    output logic sense,
    output logic busy
);
    logic [15:0] cnt;
    logic [8:0] left;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense <= 1'b0;
            busy <= 1'b0;
            cnt <= 16'h0;
            left <= 9'h0;
        end else if (start) begin
            busy <= 1'b1;
            cnt <= half;
            left <= {periods, 1'b0};
        end else if (busy && cnt > 16'h1) begin
            cnt <= cnt - 16'h1;
        end else if (busy) begin
            sense <= ~sense;
            cnt <= half;
            left <= left - 9'h1;
            busy <= left != 9'h1;
        end
    end
endmodule
`default_nettype wire

// >>> dv/fsmc_checker.sv
// Checker of the fan speed monitor, bound to its top ports
// Assumes one pclk domain and APB with zero wait states
`timescale 1ns/1ns
`default_nettype none
module fsmc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tick_100khz,
    input wire logic speed_sense_pin_in,
    input wire logic speed_sense_pin_out,
    input wire logic speed_sense_pin_oe,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr, rdc, bad, en, frz;
    logic [2:0] ien;
    logic [15:0] last;
    assign wr = psel && penable && pwrite;
    assign rdc = psel && penable && !pwrite && paddr == 12'h000;
    assign bad = paddr > 12'h014 || paddr[1:0] != 2'h0;
    // Shadow of the enable bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en <= 1'b0;
            ien <= 3'h0;
        end else if (wr && paddr == 12'h000) begin
            en <= pwdata[1];
            ien <= {pwdata[15:14], pwdata[0]};
        end else if (wr && paddr == 12'h014) begin
            ien <= {pwdata[3:2], pwdata[0]};
        end
    end
    // Count seen at the last control read, and whether the monitor was gated then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frz <= 1'b0;
            last <= 16'h0;
        end else if (rdc) begin
            frz <= !en;
            last <= prdata[31:16];
        end else if (wr && paddr == 12'h000) begin
            frz <= 1'b0;
        end
    end
    a_pin_not_driven: assert property (!speed_sense_pin_oe && !speed_sense_pin_out)
        else $error("speed-sense pin driven");
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (psel && penable && bad |-> pslverr)
        else $error("unmapped access not refused");
    a_err_only_bad: assert property (pslverr |-> psel && penable && bad)
        else $error("stray slave error");
    a_reset_idle: assert property (!$past(presetn) |-> !irq && prdata == 32'h0)
        else $error("not idle after reset");
    a_irq_masked: assert property ((ien == 3'h0) [*2] |-> !irq)
        else $error("interrupt while masked");
    a_reserved_zero: assert property (rdc |-> prdata[9] == 1'b0 && prdata[7:2] == 6'h0)
        else $error("reserved bits set");
    a_count_frozen: assert property (rdc && frz && !en |-> prdata[31:16] == last)
        else $error("count moved while gated");
endmodule
bind fsmc_top fsmc_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tick_100khz(tick_100khz), .speed_sense_pin_in(speed_sense_pin_in),
    .speed_sense_pin_out(speed_sense_pin_out), .speed_sense_pin_oe(speed_sense_pin_oe), .irq(irq));
`default_nettype wire

// >>> dv/fan_speed_monitor_control_tb.sv
// Self-checking bench of the fan speed monitor
// Assumes fsmc_top, the fan model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module fan_speed_monitor_control_tb
    import fsmc_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic tick = 1'b0, start = 1'b0, err, pready, pslverr, pin_out, pin_oe, irq, fan, busy;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [15:0] half = 16'd100, c0;
    logic [7:0] periods = 8'd1;
    logic [8:0] tdiv = 9'd0;
    // Rows: edge select, edges per interval
    logic [5:0] row [4] = '{6'h02, 6'h13, 6'h25, 6'h39};
    int fail_count = 0, n_tests = 0, cyc = 0, exp;
    wire logic pin;
    assign pin = pin_oe ? pin_out : fan;
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        tdiv <= (tdiv == 9'd499) ? 9'd0 : tdiv + 9'd1;
        tick <= tdiv == 9'd499;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            print_verdict();
        end
    end
    fsmc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tick_100khz(tick), .speed_sense_pin_in(pin), .speed_sense_pin_out(pin_out),
        .speed_sense_pin_oe(pin_oe), .irq(irq));
    fsmc_fan_model i_fan (.pclk(pclk), .presetn(presetn), .start(start), .half(half),
        .periods(periods), .sense(fan), .busy(busy));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fan_go(input logic [15:0] h, input logic [7:0] p);
        half <= h;
        periods <= p;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
    endtask
    task automatic fan_wait();
        @(posedge pclk);
        while (busy !== 1'b0)
            @(posedge pclk);
        repeat (1100)
            @(posedge pclk);
    endtask
    task automatic ready_wait();
        q = 32'h0;
        while (q[FSMC_S_READY] !== 1'b1)
            apb(1'b0, FSMC_OFF_STAT, 32'h0);
        apb(1'b1, FSMC_OFF_CLR, 32'h8);
    endtask
    initial begin
        repeat (12)
            @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({irq, pin_oe, pin_out}, 32'h0, "idle pins");
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        chk(q, 32'h0, "control reset");
        apb(1'b0, FSMC_OFF_HLIM, 32'h0);
        chk(q, 32'hffff, "high limit reset");
        apb(1'b0, 12'h018, 32'h0);
        chk(err, 32'h1, "unmapped refused");
        apb(1'b1, FSMC_OFF_CTRL, 32'h2fc);
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        chk(q, 32'h0, "reserved writes");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, FSMC_OFF_CLR, 32'hf);
            apb(1'b1, FSMC_OFF_CTRL, {19'h0, row[i][5:4], 11'h502});
            fan_go(16'd1500, {4'h0, row[i][3:0]});
            ready_wait();
            ready_wait();
            apb(1'b0, FSMC_OFF_CTRL, 32'h0);
            exp = (row[i][3:0] - 1) * 1500 / 500;
            chk(q[31:16] + 2 >= exp && q[31:16] <= exp + 2, 32'h1, "tick count");
            fan_wait();
        end
        apb(1'b1, FSMC_OFF_CTRL, 32'h2);
        fan_go(16'd100, 8'd1);
        fan_wait();
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        c0 = q[31:16];
        fan_go(16'd100, 8'd5);
        fan_wait();
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        chk(q[31:16], c0 + 16'd5, "edge count");
        apb(1'b1, FSMC_OFF_CTRL, 32'h102);
        apb(1'b1, FSMC_OFF_CLR, 32'hf);
        fan_go(16'd900, 8'd2);
        fan_wait();
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        chk(q[31:16], c0 + 16'd5, "glitch counted");
        apb(1'b0, FSMC_OFF_STAT, 32'h0);
        chk(q[2], 32'h0, "glitch reported");
        apb(1'b1, FSMC_OFF_CTRL, 32'h0);
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        fan_go(16'd100, 8'd3);
        fan_wait();
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        chk(q[31:16], c0 + 16'd5, "count while gated");
        apb(1'b1, FSMC_OFF_CTRL, 32'h2);
        fan_go(16'd100, 8'd2);
        fan_wait();
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        chk(q[31:16], c0 + 16'd7, "count resumed");
        apb(1'b1, FSMC_OFF_HLIM, 32'h0);
        apb(1'b1, FSMC_OFF_CLR, 32'hf);
        fan_go(16'd100, 8'd1);
        fan_wait();
        apb(1'b0, FSMC_OFF_STAT, 32'h0);
        chk({q[0], irq}, 32'h2, "flag while masked");
        apb(1'b1, FSMC_OFF_CTRL, 32'h3);
        @(posedge pclk);
        chk(irq, 32'h1, "irq enabled");
        apb(1'b1, FSMC_OFF_CTRL, 32'h1);
        apb(1'b0, FSMC_OFF_STAT, 32'h0);
        chk({q[0], irq}, 32'h3, "flag kept gated");
        apb(1'b1, FSMC_OFF_CTRL, 32'h3);
        apb(1'b1, FSMC_OFF_CLR, 32'h1);
        @(posedge pclk);
        chk(irq, 32'h0, "irq cleared");
        apb(1'b1, FSMC_OFF_CTRL, 32'h503);
        presetn <= 1'b0;
        repeat (2)
            @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({irq, pin_oe, pin_out}, 32'h0, "idle after reset");
        apb(1'b0, FSMC_OFF_CTRL, 32'h0);
        chk(q, 32'h0, "control after reset");
        apb(1'b0, FSMC_OFF_HLIM, 32'h0);
        chk(q, 32'hffff, "high limit after reset");
        print_verdict();
    end
endmodule
`default_nettype wire
